/* ccs_pkg.sv */
// ccs_pkg.sv: constants and types of the clock output and frame alignment block
// assumes a single 25 MHz system clock; all counts are in cycles of that clock
`default_nettype none

package ccs_pkg;

  // system clock
  localparam int CLK_KHZ = 25000;
  localparam int CLK_PS  = 40000;

  // synthesizer set
  localparam int N_SYN   = 10;
  localparam int N_GEN   = 8;
  localparam int N_SE    = 6;
  localparam int SE_BASE = 2;
  localparam int IDX_F   = 8;
  localparam int IDX_AUX = 9;

  // frequency limits in kHz and value after reset
  localparam logic [17:0] FREQ_MIN_KHZ = 18'h003e8;
  localparam logic [17:0] FREQ_MAX_KHZ = 18'h2625a;
  localparam logic [17:0] FREQ_RST_KHZ = 18'h01f40;

  // skew in steps of about 24 ps, limited to 50 ns either way
  localparam int SKEW_MAX_PS    = 50000;
  localparam int SKEW_STEP_PS   = 24;
  localparam int SKEW_LIMIT     = SKEW_MAX_PS / SKEW_STEP_PS;
  localparam int SKEW_CYC_STEPS = CLK_PS / SKEW_STEP_PS;

  // cross-couple latency compensation in 100 ps steps, up to 3.2 ns either way
  localparam int LAT_MAX_PS  = 3200;
  localparam int LAT_STEP_PS = 100;
  localparam int LAT_LIMIT   = LAT_MAX_PS / LAT_STEP_PS;

  // loop bandwidth in 0.1 Hz units; slave mode forces 100 Hz
  localparam logic [9:0] LBW_SLAVE = 10'h3e8;

  // frame timing
  localparam int PER8K_NS  = 125000;
  localparam int PER8K_CYC = PER8K_NS * 1000 / CLK_PS;
  localparam logic [11:0] PW8K_RST = 12'h010;
  localparam logic [13:0] PW2K_RST = 14'h0010;

  // pin synchronisers after reset: select pin reads master, frame and reference low
  localparam logic [2:0] PIN_RST = 3'h1;

  // frame edge: delay of synchroniser plus edge detect, and tolerance window
  localparam int EDGE_LAT = 3;
  localparam int EDGE_TOL = 2;
  localparam int WIN_HI   = EDGE_LAT + EDGE_TOL - 1;

  // composite signal high times and decode thresholds
  localparam int W_B0  = PER8K_CYC / 4;
  localparam int W_B1  = PER8K_CYC / 2;
  localparam int W_M0  = PER8K_CYC * 3 / 4;
  localparam int W_M1  = PER8K_CYC * 7 / 8;
  localparam int TH_B1 = PER8K_CYC * 3 / 8;
  localparam int TH_M0 = PER8K_CYC * 5 / 8;
  localparam int TH_M1 = PER8K_CYC * 13 / 16;

  typedef enum logic [1:0] {ARR_HF_XREF_EXT, ARR_8K_EXT, ARR_COMP_XREF, ARR_COMP_EXT} ccs_arr_t;
  typedef enum logic [1:0] {SRC_GEN, SRC_FRAME, SRC_AUX} ccs_src_t;
  typedef enum logic [1:0] {FS_8K, FS_2K, FS_COMP} ccs_fsel_t;
  typedef enum logic [1:0] {AL_OFF, AL_SEEK, AL_TRACK, AL_TEMP} ccs_align_t;

  // delay tap for a skew value: 0 earlier, 1 nominal, 2 later
  function automatic logic [1:0] skew_tap(input logic signed [11:0] s);
    if (s >= SKEW_CYC_STEPS)
    begin
      return 2'h2;
    end
    if (s <= -SKEW_CYC_STEPS)
    begin
      return 2'h0;
    end
    return 2'h1;
  endfunction : skew_tap

endpackage : ccs_pkg

`default_nettype wire

/* ccs_synth.sv */
// ccs_synth.sv: one clock synthesizer, phase accumulator with skew delay taps
// assumes frequency and skew are stable between writes; align_in is one cycle
`default_nettype none

module ccs_synth
  import ccs_pkg::*;
#(
  parameter bit ALIGN_EN = 1'b1
)
(
  // clock and reset
  input  wire logic               clk_in,
  input  wire logic               rst_in,
  // settings
  input  wire logic [17:0]        freq_in,
  input  wire logic signed [11:0] skew_in,
  input  wire logic               align_in,
  // clock
  output logic                    clk_out
);

  typedef struct packed {
    logic [14:0] acc;
    logic [1:0]  dly;
    logic        q;
  } ccs_syn_st_t;

  ccs_syn_st_t st;
  ccs_syn_st_t nx;
  logic [14:0] step;
  logic [15:0] sum;
  logic        cur;

  // outputs above half the system clock alias; frequency is the mean edge rate
  always_comb
  begin
    nx   = st;
    step = 15'(freq_in % CLK_KHZ);
    sum  = {1'b0, st.acc} + {1'b0, step};
    cur  = st.acc < 15'(CLK_KHZ / 2);
    if (sum >= 16'(CLK_KHZ))
    begin
      nx.acc = 15'(sum - 16'(CLK_KHZ));
    end
    else
    begin
      nx.acc = sum[14:0];
    end
    // restart phase on the frame boundary for multiples of 8 kHz, see [R10]
    if (ALIGN_EN && align_in && freq_in[2:0] == 3'h0)
    begin
      nx.acc = '0;
    end
    nx.dly = {st.dly[0], cur};
    case (skew_tap(skew_in)) // see [R3]
      2'h0:    nx.q = cur;
      2'h1:    nx.q = st.dly[0];
      default: nx.q = st.dly[1];
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      st <= '0;
    end
    else
    begin
      st <= nx;
    end
  end

  assign clk_out = st.q;

endmodule : ccs_synth

`default_nettype wire

/* ccs_top.sv */
// ccs_top.sv: clock outputs, frame pulse synthesizer and redundancy frame alignment
// assumes pins are asynchronous to clk_in and all settings come from clk_in logic
`default_nettype none

// How it works
// [R1] ten synthesizers: eight general, frame, auxiliary
// [R2] general frequency 1 MHz to 156.25 MHz
// [R3] per-synthesizer skew up to 50 ns
// [R4] differential outputs from first two synthesizers
// [R5] single-ended outputs pick own, frame or auxiliary
// [R6] frame mux picks 8k, 2k or composite
// [R7] separate pulse widths for 8k and 2k
// [R8] frame outputs carry 8k and 2k pulses
// [R9] composite carries 8k, 2k marker, reference
// [R10] 8 kHz multiples align with 8k frame; code aligns general synthesizers only, not auxiliary
// [R11] one skew setting shifts all frame clocks
// [R12] external frame edge when reference lacks frame
// [R13] select pin: 0 slave, 1 master
// [R14] slave locks with fixed 100 Hz bandwidth
// [R15] four master-to-slave frame arrangements
// [R16] 2 kHz alignment needs no 8k-only arrangement
// [R17] edge error sets flag, uses own frame
// [R18] relock request reselects the frame edge
// [R19] external frame sampled on programmed edge
// [R20] new master inherits old master's reference
// [R21] signed cross-couple latency compensation
// [R22] frame align register enters frame align mode
// [R23] multiple masters share identical setup
// [R24] revertive elector pre-empts on higher priority
module ccs_top
  import ccs_pkg::*;
(
  // clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   rst_in,
  // pins from the partner device
  input  wire logic                   master_slave_select_in,
  input  wire logic                   external_frame_in,
  input  wire logic                   seventh_reference_in,
  // synthesizer programming
  input  wire logic [3:0]             synth_index_in,
  input  wire logic [17:0]            synth_freq_in,
  input  wire logic                   synth_freq_wr_in,
  input  wire logic signed [11:0]     synth_skew_in,
  input  wire logic                   synth_skew_wr_in,
  // output configuration
  input  wire logic                   diff_std_sel_in,
  input  wire logic [N_SE-1:0][1:0]   se_src_sel_in,
  input  wire logic [N_SE-1:0][1:0]   se_frame_sel_in,
  input  wire logic [11:0]            pulse_w8k_in,
  input  wire logic [13:0]            pulse_w2k_in,
  // redundancy configuration
  input  wire logic [1:0]             slave_arr_in,
  input  wire logic                   slave_edge_fall_in,
  input  wire logic [1:0]             master_arr_in,
  input  wire logic                   master_edge_fall_in,
  input  wire logic                   frame_align_wr_in,
  input  wire logic                   relock_in,
  input  wire logic [9:0]             loop_bw_in,
  input  wire logic signed [6:0]      latency_comp_in,
  // reference election
  input  wire logic                   auto_sel_in,
  input  wire logic                   revertive_in,
  input  wire logic                   inherit_in,
  input  wire logic                   qual_match_in,
  input  wire logic                   rec_valid_in,
  input  wire logic [3:0]             rec_ref_in,
  input  wire logic [3:0]             rec_prio_in,
  input  wire logic                   cand_qual_in,
  input  wire logic [3:0]             manual_ref_in,
  // clock outputs
  output logic                        diff_out_a,
  output logic                        diff_out_b,
  output logic                        diff_std_out,
  output logic [N_SE-1:0]             single_ended_outs_out,
  output logic                        frame_8k_out,
  output logic                        frame_2k_out,
  // status
  output logic                        frame_edge_error_out,
  output logic                        frame_align_mode_out,
  output logic                        slave_mode_out,
  output logic [9:0]                  loop_bw_out,
  output logic [3:0]                  selected_ref_out,
  output logic signed [6:0]           latency_comp_out
);

  typedef struct packed {
    logic [2:0]         s1;
    logic [2:0]         s2;
    logic [2:0]         pv;
    logic [9:0][17:0]   freq;
    logic [9:0][11:0]   skew;
    logic [11:0]        cnt;
    logic [1:0]         per;
    logic [1:0][2:0]    fdly;
    logic [2:0]         ftap;
    logic               f8o;
    logic               f2o;
    ccs_align_t         ast;
    logic               ferr;
    logic               fam;
    ccs_arr_t           marr;
    logic               medge;
    logic [11:0]        hcnt;
    logic [1:0]         dpos;
    logic [3:0]         dtmp;
    logic [3:0]         dref;
    logic [3:0]         cand;
    logic [3:0]         cprio;
    logic [3:0]         refq;
    logic               slave;
    logic [9:0]         lbw;
    logic signed [6:0]  lat;
    logic [N_SE-1:0]    se;
    logic               da;
    logic               db;
    logic               dstd;
  } ccs_st_t;

  ccs_st_t         st;
  ccs_st_t         nx;
  logic [8:0]      syn_clk;
  logic [N_SE-1:0] se_nx;
  logic [N_SE-1:0] se_frm;
  logic            wrap;
  logic            slave_c;
  logic            active;
  logic            comp;
  logic            efall;
  logic            fs;
  logic            fp;
  logic            rise;
  logic            fall;
  logic            edge_c;
  logic            dbit;
  logic [2:0]      fcur;
  logic [11:0]     cw;
  logic [13:0]     pos2k;
  ccs_arr_t        arr;

  assign wrap = st.cnt == 12'(PER8K_CYC - 1);

  // general synthesizers 0..7 and the auxiliary one at slot 8, see [R1]
  for (genvar i = 0; i < 9; i++)
  begin : g_syn
    localparam int K = (i == 8) ? IDX_AUX : i;
    ccs_synth #(.ALIGN_EN(i < N_GEN)) u_syn (
      .clk_in   (clk_in),
      .rst_in   (rst_in),
      .freq_in  (st.freq[K]),
      .skew_in  (st.skew[K]),
      .align_in (wrap),
      .clk_out  (syn_clk[i])
    );
  end

  // per-output frame mux and source mux, see [R5] [R6]
  for (genvar j = 0; j < N_SE; j++)
  begin : g_se
    assign se_frm[j] = (se_frame_sel_in[j] == FS_8K) ? st.ftap[0] :
                       (se_frame_sel_in[j] == FS_2K) ? st.ftap[1] : st.ftap[2];
    assign se_nx[j]  = (se_src_sel_in[j] == SRC_FRAME) ? se_frm[j] :
                       (se_src_sel_in[j] == SRC_AUX)   ? syn_clk[8] : syn_clk[j + SE_BASE];
  end

  always_comb
  begin
    nx      = st;
    nx.s1   = {seventh_reference_in, external_frame_in, master_slave_select_in};
    nx.s2   = st.s1;
    nx.pv   = st.s2;
    slave_c = ~st.s2[0]; // see [R13]
    active  = slave_c | st.fam;
    // each mode has its own arrangement and edge, see [R13] [R15]
    arr     = slave_c ? ccs_arr_t'(slave_arr_in) : st.marr;
    efall   = slave_c ? slave_edge_fall_in : st.medge;
    comp    = (arr == ARR_COMP_XREF) || (arr == ARR_COMP_EXT);
    fs      = (arr == ARR_COMP_XREF) ? st.s2[2] : st.s2[1];
    fp      = (arr == ARR_COMP_XREF) ? st.pv[2] : st.pv[1];
    rise    = fs & ~fp;
    fall    = ~fs & fp;
    edge_c  = (comp || !efall) ? rise : fall; // see [R12] [R19]
    dbit    = st.hcnt >= 12'(TH_B1);

    // synthesizer programming, frame slot has no frequency, see [R2] [R3]
    if (synth_freq_wr_in && synth_index_in < 4'(N_SYN) && synth_index_in != 4'(IDX_F))
    begin
      if (synth_freq_in < FREQ_MIN_KHZ)
      begin
        nx.freq[synth_index_in] = FREQ_MIN_KHZ;
      end
      else if (synth_freq_in > FREQ_MAX_KHZ)
      begin
        nx.freq[synth_index_in] = FREQ_MAX_KHZ;
      end
      else
      begin
        nx.freq[synth_index_in] = synth_freq_in;
      end
    end
    if (synth_skew_wr_in && synth_index_in < 4'(N_SYN))
    begin
      if (int'(synth_skew_in) > SKEW_LIMIT)
      begin
        nx.skew[synth_index_in] = 12'(SKEW_LIMIT);
      end
      else if (int'(synth_skew_in) < -SKEW_LIMIT)
      begin
        nx.skew[synth_index_in] = -12'(SKEW_LIMIT);
      end
      else
      begin
        nx.skew[synth_index_in] = synth_skew_in;
      end
    end

    // frame pulse synthesizer: 8k counter and 2k period index
    nx.cnt = wrap ? 12'h000 : st.cnt + 12'h001;
    if (wrap)
    begin
      nx.per = st.per + 2'h1;
    end
    pos2k   = 14'(st.per) * 14'(PER8K_CYC) + 14'(st.cnt);
    fcur[0] = st.cnt < pulse_w8k_in; // see [R7]
    fcur[1] = pos2k < pulse_w2k_in; // see [R7]
    // composite: marker width holds ref bit 3, later periods bits 2..0, see [R9]
    if (st.per == 2'h0)
    begin
      cw = st.refq[3] ? 12'(W_M1) : 12'(W_M0);
    end
    else
    begin
      cw = st.refq[2'h3 - st.per] ? 12'(W_B1) : 12'(W_B0);
    end
    fcur[2] = st.cnt < cw;
    nx.fdly = {st.fdly[0], fcur};
    case (skew_tap(st.skew[IDX_F])) // see [R11]
      2'h0:    nx.ftap = fcur;
      2'h1:    nx.ftap = st.fdly[0];
      default: nx.ftap = st.fdly[1];
    endcase
    nx.f8o = st.ftap[0]; // see [R8]
    nx.f2o = st.ftap[1]; // see [R8]
    nx.se   = se_nx;
    nx.da   = syn_clk[0]; // see [R4]
    nx.db   = syn_clk[1]; // see [R4]
    nx.dstd = diff_std_sel_in; // see [R4]

    // frame alignment
    nx.ferr = st.ferr & ~relock_in;
    if (frame_align_wr_in)
    begin
      nx.fam   = 1'b1; // see [R22]
      nx.marr  = ccs_arr_t'(master_arr_in);
      nx.medge = master_edge_fall_in;
    end
    case (st.ast)
      AL_OFF:
      begin
        nx.ast = AL_SEEK;
      end
      AL_SEEK:
      begin
        if (edge_c)
        begin
          nx.cnt = 12'(EDGE_LAT);
          // an 8k-only frame input cannot place the 2k frame, see [R16]
          if (arr == ARR_HF_XREF_EXT)
          begin
            nx.per = 2'h0;
          end
          nx.ast = AL_TRACK;
        end
      end
      AL_TRACK:
      begin
        if (edge_c && st.cnt <= 12'(WIN_HI))
        begin
          nx.cnt = 12'(EDGE_LAT);
        end
        else if (edge_c)
        begin
          // own 8k frame stands in as the reference from here on, see [R17]
          nx.ferr = 1'b1;
          nx.ast = AL_TEMP;
        end
      end
      AL_TEMP:
      begin
        nx.ast = AL_TEMP;
      end
      default:
      begin
        nx.ast = AL_OFF;
      end
    endcase
    if (!active)
    begin
      nx.ast = AL_OFF;
    end
    else if (relock_in || frame_align_wr_in)
    begin
      nx.ast = AL_SEEK; // see [R18] [R22]
    end

    // composite decoder: high time classifies marker or data bit
    if (rise)
    begin
      nx.hcnt = 12'h000;
    end
    else if (fs && st.hcnt != 12'hfff)
    begin
      nx.hcnt = st.hcnt + 12'h001;
    end
    if (fall && comp)
    begin
      if (st.hcnt >= 12'(TH_M0))
      begin
        nx.dtmp[3] = st.hcnt >= 12'(TH_M1);
        nx.dpos    = 2'h1;
        if (st.ast == AL_TRACK)
        begin
          nx.per = 2'h0;
        end
      end
      else if (st.dpos != 2'h0)
      begin
        nx.dtmp[2'h3 - st.dpos] = dbit;
        nx.dpos = st.dpos + 2'h1;
        if (st.dpos == 2'h3)
        begin
          nx.dref = {st.dtmp[3:1], dbit};
        end
      end
    end

    // elector: revertive pre-empts on higher priority, else waits, see [R24]
    if (rec_valid_in && (!cand_qual_in || st.cprio == 4'h0 ||
        (revertive_in && rec_prio_in < st.cprio)))
    begin
      nx.cand  = rec_ref_in;
      nx.cprio = rec_prio_in;
    end
    // slave turning master keeps the old master's reference, see [R20]
    if (st.s2[0] && !st.pv[0] && auto_sel_in && inherit_in && !revertive_in && qual_match_in)
    begin
      nx.cand = st.dref;
    end
    nx.refq  = slave_c ? st.dref : (auto_sel_in ? st.cand : manual_ref_in); // see [R14]
    nx.slave = slave_c;
    nx.lbw   = slave_c ? LBW_SLAVE : loop_bw_in; // see [R14]
    if (!slave_c)
    begin
      nx.lat = 7'sh00;
    end
    else if (latency_comp_in > 7'(LAT_LIMIT))
    begin
      nx.lat = 7'(LAT_LIMIT); // see [R21]
    end
    else if (latency_comp_in < -7'(LAT_LIMIT))
    begin
      nx.lat = -7'(LAT_LIMIT);
    end
    else
    begin
      nx.lat = latency_comp_in;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      st      <= '0;
      st.freq <= {N_SYN{FREQ_RST_KHZ}};
      st.s1   <= PIN_RST;
      st.s2   <= PIN_RST;
      st.pv   <= PIN_RST;
    end
    else
    begin
      st <= nx;
    end
  end

  assign diff_out_a            = st.da;
  assign diff_out_b            = st.db;
  assign diff_std_out          = st.dstd;
  assign single_ended_outs_out = st.se;
  assign frame_8k_out          = st.f8o;
  assign frame_2k_out          = st.f2o;
  assign frame_edge_error_out  = st.ferr;
  assign frame_align_mode_out  = st.fam;
  assign slave_mode_out        = st.slave;
  assign loop_bw_out           = st.lbw;
  assign selected_ref_out      = st.refq;
  assign latency_comp_out      = st.lat;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  slave_bw_a: assert property (slave_mode_out |-> loop_bw_out == LBW_SLAVE) // see [R14]
    else $error("slave loop bandwidth not fixed");
  ferr_hold_a: assert property (st.ferr && !relock_in |=> st.ferr) // see [R17]
    else $error("frame edge error dropped without relock");
  ferr_temp_a: assert property ($rose(st.ferr) |-> st.ast == AL_TEMP) // see [R17]
    else $error("edge error without temporary frame reference");
  relock_seek_a: assert property (relock_in && slave_c |=> st.ast == AL_SEEK) // see [R18]
    else $error("relock did not restart edge search");
  frame_wrap_a: assert property (wrap && !edge_c |=> st.cnt == 12'h000 ##1 // see [R8]
      (st.cnt == 12'h001 || $past(edge_c)))
    else $error("8k frame counter wrong");
  align_mode_a: assert property (frame_align_wr_in |=> frame_align_mode_out) // see [R22]
    else $error("frame align mode not entered");
  freq_range_a: assert property (synth_freq_wr_in && synth_index_in == 4'h1 |=> // see [R2]
      st.freq[1] >= FREQ_MIN_KHZ && st.freq[1] <= FREQ_MAX_KHZ)
    else $error("synth frequency out of range");
  skew_store_a: assert property (synth_skew_wr_in && synth_index_in == 4'h9 |=> // see [R3]
      st.skew[9] == $past(synth_skew_in))
    else $error("synth skew not stored");
  aux_route_a: assert property (se_src_sel_in[1] == SRC_AUX |=> // see [R5]
      single_ended_outs_out[1] == $past(syn_clk[8]))
    else $error("aux synth not routed");

  ferr_seen_c: cover property ($rose(st.ferr));
  track_c: cover property (st.ast == AL_SEEK ##1 st.ast == AL_TRACK);
  ref_decoded_c: cover property (fall && comp && st.dpos == 2'h3);

endmodule : ccs_top

`default_nettype wire

/* ccs_peer.sv */
// ccs_peer.sv: behavioural peer master that drives the frame and cross reference pins
// assumes the bench time base; the slave is set to take the 8k pulse on its frame pin
`default_nettype none

module ccs_peer
#(
  parameter int FRAME_NS = 125000,
  parameter int PW_NS    = 640
)
(
  // control
  input  wire logic bad_in,
  // pins
  output var logic  frame_out,
  output var logic  ref_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // 8k only on the frame pin, so no 2k alignment is asked of the slave
  initial
  begin
    frame_out = 1'b0;
    ref_out = 1'b0;
    forever
    begin
      #(FRAME_NS - PW_NS);
      frame_out = 1'b1;
      #(PW_NS);
      frame_out = 1'b0;
    end
  end

  // one misplaced edge a third of a frame after each request
  always @(posedge bad_in)
  begin
    #(FRAME_NS / 3);
    frame_out = 1'b1;
    #(PW_NS);
    frame_out = 1'b0;
  end

  // free-running cross reference clock
  always #77 ref_out = ~ref_out;

endmodule : ccs_peer

`default_nettype wire

/* ccs_top_tb_top.sv */
// ccs_top_tb_top.sv: self-checking bench of the clock output and frame alignment block
// assumes ccs_pkg, ccs_top and ccs_peer are compiled before it
`default_nettype none

module ccs_top_tb_top
  import ccs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {string nm; logic [31:0] v;} ccs_note_t;

  logic clk_in, rst_in, master_slave_select_in, external_frame_in, seventh_reference_in;
  logic synth_freq_wr_in, synth_skew_wr_in, diff_std_sel_in, slave_edge_fall_in;
  logic master_edge_fall_in, frame_align_wr_in, relock_in, auto_sel_in, revertive_in;
  logic inherit_in, qual_match_in, rec_valid_in, cand_qual_in, bad;
  logic diff_out_a, diff_out_b, diff_std_out, frame_8k_out, frame_2k_out;
  logic frame_edge_error_out, frame_align_mode_out, slave_mode_out;
  logic [1:0]           slave_arr_in, master_arr_in;
  logic [3:0]           synth_index_in, rec_ref_in, rec_prio_in, manual_ref_in, selected_ref_out;
  logic [17:0]          synth_freq_in;
  logic signed [11:0]   synth_skew_in;
  logic [N_SE-1:0][1:0] se_src_sel_in, se_frame_sel_in;
  logic [N_SE-1:0]      single_ended_outs_out;
  logic [11:0]          pulse_w8k_in;
  logic [13:0]          pulse_w2k_in;
  logic [9:0]           loop_bw_in, loop_bw_out, obs, prv;
  logic signed [6:0]    latency_comp_in, latency_comp_out;
  logic [31:0]          res_v;
  logic [15:0]          el [5] = '{16'h7535, 16'h7727, 16'h5917, 16'h4919, 16'h0912};
  ccs_note_t            exp_q[$];
  ccs_note_t            nt;
  event                 res_ev;
  int                   n_mismatch, num_checks, seed, hi, per;

  assign obs = {frame_2k_out, frame_8k_out, single_ended_outs_out, diff_out_b, diff_out_a};

  ccs_top uut (.*);
  ccs_peer peer (.bad_in(bad), .frame_out(external_frame_in), .ref_out(seventh_reference_in));

  initial
  begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    exp_q.push_back('{nm, e});
    res_v = g;
    -> res_ev;
    #1;
  endtask : chk

  always @(res_ev)
  begin
    nt = exp_q.pop_front();
    num_checks++;
    if (res_v !== nt.v)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %0h seen %0h", nt.nm, nt.v, res_v);
    end
  end

  task automatic wr(input logic [3:0] ix, input logic [17:0] f, input logic signed [11:0] s);
    @(negedge clk_in);
    synth_index_in = ix;
    synth_freq_in = f;
    synth_skew_in = s;
    synth_freq_wr_in = 1'b1;
    synth_skew_wr_in = 1'b1;
    @(negedge clk_in);
    synth_freq_wr_in = 1'b0;
    synth_skew_wr_in = 1'b0;
  endtask : wr

  task automatic strobe(ref logic s);
    @(negedge clk_in);
    s = 1'b1;
    @(negedge clk_in);
    s = 1'b0;
  endtask : strobe

  // bounded wait for a low then a high sample of one watched output
  task automatic rise(input int k);
    int n;
    n = 0;
    while (obs[k] !== 1'b0 && n < 16'h7530)
    begin
      @(negedge clk_in);
      n++;
    end
    while (obs[k] !== 1'b1 && n < 16'h7530)
    begin
      prv = obs;
      @(negedge clk_in);
      n++;
    end
  endtask : rise

  task automatic meas(input int k);
    rise(k);
    hi = 1;
    per = 1;
    @(negedge clk_in);
    while (obs[k] === 1'b1 && per < 16'h7530)
    begin
      hi++;
      per++;
      @(negedge clk_in);
    end
    while (obs[k] !== 1'b1 && per < 16'h7530)
    begin
      per++;
      @(negedge clk_in);
    end
  endtask : meas

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  initial
  begin
    #3800us;
    n_mismatch++;
    end_sim();
  end

  initial
  begin
    seed = 32'h0652e76f;
    {rst_in, master_slave_select_in, rec_valid_in, diff_std_sel_in} = 4'hf;
    {bad, synth_freq_wr_in, synth_skew_wr_in, frame_align_wr_in, relock_in} = '0;
    {auto_sel_in, revertive_in, inherit_in, qual_match_in, cand_qual_in} = '0;
    {rec_ref_in, rec_prio_in, synth_index_in, synth_freq_in, synth_skew_in} = '0;
    manual_ref_in = 4'h2;
    // se0 2k frame, se1 aux, se2 own, se3 8k frame, se4 own
    se_src_sel_in = {2'h0, 2'h0, 2'h1, 2'h0, 2'h2, 2'h1};
    se_frame_sel_in = {2'h2, 2'h2, 2'h0, 2'h2, 2'h2, 2'h1};
    pulse_w8k_in = 12'(12'h014 + $unsigned($random(seed)) % 12'h0c8);
    pulse_w2k_in = 14'(14'h0014 + $unsigned($random(seed)) % 14'h07d0);
    loop_bw_in = 10'($random(seed));
    latency_comp_in = 7'h28;
    {slave_arr_in, slave_edge_fall_in} = 3'h2;
    {master_arr_in, master_edge_fall_in} = 3'($random(seed));
    repeat (12) @(negedge clk_in);
    rst_in = 1'b0;
    repeat (5) @(negedge clk_in);
    chk("slave_mode", 32'h0, slave_mode_out);
    chk("loop_bw", loop_bw_in, loop_bw_out);
    chk("latency", 32'h0, latency_comp_out);
    chk("diff_std", 32'h1, diff_std_out);
    wr(4'h0, 18'h003e8, 12'($random(seed) % 1000));
    wr(4'h1, 18'h001f4, 12'h000);
    wr(4'h9, 18'h009c4, 12'h800);
    wr(4'h4, 18'h00c35, 12'h000);
    meas(0);
    chk("a_period", 32'h19, per);
    meas(1);
    chk("b_period_clamped", 32'h19, per);
    meas(3);
    chk("aux_period", 32'ha, per);
    meas(4);
    chk("own_period", 32'h8, per);
    meas(8);
    chk("f8k_width", pulse_w8k_in, hi);
    chk("f8k_period", 32'hc35, per);
    meas(9);
    chk("f2k_width", pulse_w2k_in, hi);
    chk("f2k_period", 32'h30d4, per);
    meas(2);
    chk("se_2k_width", pulse_w2k_in, hi);
    chk("se_2k_period", 32'h30d4, per);
    meas(5);
    chk("se_8k_width", pulse_w8k_in, hi);
    rise(8);
    chk("aligned", 32'h1, {prv[6], obs[6]});
    for (int i = 0; i < 5; i++)
    begin
      @(negedge clk_in);
      {auto_sel_in, revertive_in, cand_qual_in, rec_ref_in, rec_prio_in} = el[i][14:4];
      repeat (3) @(negedge clk_in);
      chk("selected_ref", el[i][3:0], selected_ref_out);
    end
    master_slave_select_in = 1'b0;
    repeat (16'h1f40) @(negedge clk_in);
    chk("slave_mode", 32'h1, slave_mode_out);
    chk("loop_bw_slave", 32'h3e8, loop_bw_out);
    chk("latency_slave", 32'h20, latency_comp_out);
    chk("tracking", 32'h0, frame_edge_error_out);
    @(posedge external_frame_in);
    @(negedge clk_in);
    bad = 1'b1;
    repeat (16'h07d0) @(negedge clk_in);
    bad = 1'b0;
    chk("edge_error", 32'h1, frame_edge_error_out);
    chk("slave_kept", 32'h1, slave_mode_out);
    slave_edge_fall_in = 1'b1;
    strobe(relock_in);
    repeat (3) @(negedge clk_in);
    chk("error_cleared", 32'h0, frame_edge_error_out);
    repeat (16'h1f40) @(negedge clk_in);
    chk("relocked", 32'h0, frame_edge_error_out);
    strobe(frame_align_wr_in);
    repeat (4) @(negedge clk_in);
    chk("align_mode", 32'h1, frame_align_mode_out);
    end_sim();
  end

endmodule : ccs_top_tb_top

`default_nettype wire
